/* File: verilog/cogc_cal.v */
// Notes on behaviour
// - Under serial control the host picks chop rate modulator_rate/32 or /8.
// - Chop rate defaults to /32 and is forced to /32 in strap mode.
// - Offset and gain are per channel and writable only under serial control.
// - Offset is 24-bit two's complement in high, middle and low bytes.
// - At nominal gain, one offset count moves output by minus four thirds.
// - Offset is subtracted before gain so its effect scales with gain.
// - Reset returns every channel offset to its factory default.
// - Gain is three bytes per channel, factory set near nominal.
// - Host may overwrite gain; reset restores the factory gain.
// - Output is (raw - offset) * gain/4 * 4194300 / 2^42.
// - One gain count changes channel gain by about 0.179 ppm at nominal gain.
`timescale 1ns/100ps
`include "cogc_map.vh"

module cogc_cal (
    input wire ref_clk,
    input wire rst_b,
    input wire pin_ctrl_mode,
    input wire mod_tick,
    input wire [`COGC_AW-1:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wdata,
    input wire reg_rd_en,
    output reg [7:0] reg_rdata,
    input wire raw_valid,
    input wire [`COGC_CHW-1:0] raw_chan,
    input wire [`COGC_DW-1:0] raw_data,
    output reg cal_valid,
    output reg [`COGC_CHW-1:0] cal_chan,
    output reg [`COGC_DW-1:0] cal_data,
    output reg chop_div8,
    output wire chop_pulse
);

////////////////////////////////////////////////////////////////////////////////
// Strap synchroniser

reg pin_meta_r;
reg pin_mode_r;

// The strap is a pin from outside this clock, so two flops before use
// Reset clears the sync, so serial control is assumed for two cycles after it
always @(posedge ref_clk) begin
    if (!rst_b) begin
        pin_meta_r <= 1'b0;
        pin_mode_r <= 1'b0;
    end else begin
        pin_meta_r <= pin_ctrl_mode;
        pin_mode_r <= pin_meta_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register decode

reg [`COGC_DW-1:0] ofs_mem [0:`COGC_CH_N-1];
reg [`COGC_DW-1:0] gain_mem [0:`COGC_CH_N-1];
reg chop_sel_r;
wire [`COGC_CHW-1:0] acc_chan;
wire [2:0] acc_slot;
wire in_chan_space;
wire wr_ok;
integer i;

// Channel bytes live below the channel span; slot picks the byte
// Slots six and seven of every channel are holes: writes dropped, reads zero
assign acc_chan = reg_addr[`COGC_CHAN_MSB:`COGC_CHAN_LSB];
assign acc_slot = reg_addr[`COGC_SLOT_MSB:`COGC_SLOT_LSB];
assign in_chan_space = (reg_addr < `COGC_CH_SPAN);
// Strap mode locks out every calibration write
assign wr_ok = reg_wr_en && !pin_mode_r;

////////////////////////////////////////////////////////////////////////////////
// Coefficient storage

// Factory values come back on every reset; host writes are lost
// Each byte lands alone, so a coefficient is briefly mixed while its bytes go in
always @(posedge ref_clk) begin
    if (!rst_b) begin
        for (i = 0; i < `COGC_CH_N; i = i + 1) begin
            ofs_mem[i] <= `COGC_OFS_FACTORY;
            gain_mem[i] <= `COGC_GAIN_FACTORY;
        end
    end else if (wr_ok && in_chan_space) begin
        case (acc_slot)
            `COGC_SLOT_OFS_HI: begin
                ofs_mem[acc_chan][23:16] <= reg_wdata;
            end
            `COGC_SLOT_OFS_MID: begin
                ofs_mem[acc_chan][15:8] <= reg_wdata;
            end
            `COGC_SLOT_OFS_LO: begin
                ofs_mem[acc_chan][7:0] <= reg_wdata;
            end
            `COGC_SLOT_GAIN_HI: begin
                gain_mem[acc_chan][23:16] <= reg_wdata;
            end
            `COGC_SLOT_GAIN_MID: begin
                gain_mem[acc_chan][15:8] <= reg_wdata;
            end
            `COGC_SLOT_GAIN_LO: begin
                gain_mem[acc_chan][7:0] <= reg_wdata;
            end
            default: begin
            end
        endcase
    end
end

// Chop selection byte, default divide by 32
always @(posedge ref_clk) begin
    if (!rst_b) begin
        chop_sel_r <= 1'b0;
    end else if (wr_ok && (reg_addr == `COGC_ADDR_CHOP_CTRL)) begin
        chop_sel_r <= reg_wdata[`COGC_CHOP_SEL_BIT];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read path

reg [7:0] rd_nxt;
reg [`COGC_DW-1:0] rd_ofs;
reg [`COGC_DW-1:0] rd_gain;

// Byte select for reads; unmapped bytes answer zero
// A read in the cycle of a write to the same byte returns the old value
always @* begin
    rd_ofs = ofs_mem[acc_chan];
    rd_gain = gain_mem[acc_chan];
    rd_nxt = 8'h00;
    if (in_chan_space) begin
        case (acc_slot)
            `COGC_SLOT_OFS_HI: begin
                rd_nxt = rd_ofs[23:16];
            end
            `COGC_SLOT_OFS_MID: begin
                rd_nxt = rd_ofs[15:8];
            end
            `COGC_SLOT_OFS_LO: begin
                rd_nxt = rd_ofs[7:0];
            end
            `COGC_SLOT_GAIN_HI: begin
                rd_nxt = rd_gain[23:16];
            end
            `COGC_SLOT_GAIN_MID: begin
                rd_nxt = rd_gain[15:8];
            end
            `COGC_SLOT_GAIN_LO: begin
                rd_nxt = rd_gain[7:0];
            end
            default: begin
                rd_nxt = 8'h00;
            end
        endcase
    end else if (reg_addr == `COGC_ADDR_CHOP_CTRL) begin
        rd_nxt[`COGC_CHOP_SEL_BIT] = chop_sel_r;
    end else if (reg_addr == `COGC_ADDR_STATUS) begin
        rd_nxt[`COGC_STAT_PIN_BIT] = pin_mode_r;
        rd_nxt[`COGC_STAT_CHOP_BIT] = chop_div8;
    end
end

// Read data is registered and holds until the next read
always @(posedge ref_clk) begin
    if (!rst_b) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
        reg_rdata <= rd_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Chop rate

// Strap mode pins the rate at /32 whatever the register holds
// Registered, so the divider sees a clean level one cycle after the write
always @(posedge ref_clk) begin
    if (!rst_b) begin
        chop_div8 <= 1'b0;
    end else begin
        chop_div8 <= chop_sel_r && !pin_mode_r;
    end
end

// Divider counts modulator ticks; a new ratio is picked up at the next tick
cogc_chop_div u_chop_div (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .mod_tick(mod_tick),
    .div8_sel(chop_div8),
    .chop_pulse(chop_pulse)
);

////////////////////////////////////////////////////////////////////////////////
// Stage 1: offset subtraction

reg s1_vld_r;
reg [`COGC_CHW-1:0] s1_chan_r;
reg signed [`COGC_DW:0] s1_diff_r;
reg [`COGC_DW-1:0] s1_gain_r;
wire signed [`COGC_DW:0] raw_ext;
wire signed [`COGC_DW:0] ofs_ext;

// Sign extend by one bit so the difference never wraps
assign raw_ext = {raw_data[`COGC_DW-1], raw_data};
assign ofs_ext = {ofs_mem[raw_chan][`COGC_DW-1], ofs_mem[raw_chan]};

// Offset comes off first, before any gain is applied
// Coefficients are taken with the raw word, so a later write hits the next sample
always @(posedge ref_clk) begin
    if (!rst_b) begin
        s1_vld_r <= 1'b0;
        s1_chan_r <= {`COGC_CHW{1'b0}};
        s1_diff_r <= {(`COGC_DW+1){1'b0}};
        s1_gain_r <= {`COGC_DW{1'b0}};
    end else begin
        s1_vld_r <= raw_valid;
        if (raw_valid) begin
            s1_chan_r <= raw_chan;
            s1_diff_r <= raw_ext - ofs_ext;
            s1_gain_r <= gain_mem[raw_chan];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Stage 2: gain multiply

reg s2_vld_r;
reg [`COGC_CHW-1:0] s2_chan_r;
reg signed [`COGC_PROD1_W-1:0] s2_prod_r;
wire signed [`COGC_DW:0] gain_ext;

// Gain is unsigned; a zero top bit keeps the signed product honest
assign gain_ext = {1'b0, s1_gain_r};

// Full-width product, so every gain count is felt (about 0.179 ppm each at nominal gain)
// A 25 by 25 signed product needs 50 bits; anything narrower would wrap
always @(posedge ref_clk) begin
    if (!rst_b) begin
        s2_vld_r <= 1'b0;
        s2_chan_r <= {`COGC_CHW{1'b0}};
        s2_prod_r <= {`COGC_PROD1_W{1'b0}};
    end else begin
        s2_vld_r <= s1_vld_r;
        if (s1_vld_r) begin
            s2_chan_r <= s1_chan_r;
            s2_prod_r <= s1_diff_r * gain_ext;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Stage 3: fixed scale, shift and saturation

wire signed [`COGC_DW:0] scale_ext;
wire signed [`COGC_PROD2_W-1:0] prod2;
wire signed [`COGC_RES_W-1:0] res;
wire res_pos_ok;
wire res_neg_ok;
wire ovf;
reg [`COGC_DW-1:0] sat_nxt;

// Divide by four and by 2^42 as one arithmetic shift; floor rounding
assign scale_ext = {1'b0, `COGC_SCALE_MUL};
assign prod2 = s2_prod_r * scale_ext;
assign res = prod2[`COGC_PROD2_W-1:`COGC_SCALE_SHIFT];

// Result fits only if the bits above bit 23 all copy the sign
assign res_pos_ok = (res[`COGC_RES_W-1:`COGC_DW-1] == {(`COGC_RES_W-`COGC_DW+1){1'b0}});
assign res_neg_ok = (res[`COGC_RES_W-1:`COGC_DW-1] == {(`COGC_RES_W-`COGC_DW+1){1'b1}});
// Either pattern means the value needs no clamp
assign ovf = !res_pos_ok && !res_neg_ok;

// Clamp instead of wrapping, so large corrections stay monotonic
always @* begin
    sat_nxt = res[`COGC_DW-1:0];
    if (ovf) begin
        if (res[`COGC_RES_W-1]) begin
            sat_nxt = `COGC_OUT_MIN;
        end else begin
            sat_nxt = `COGC_OUT_MAX;
        end
    end
end

// Output register; data holds between results
always @(posedge ref_clk) begin
    if (!rst_b) begin
        cal_valid <= 1'b0;
        cal_chan <= {`COGC_CHW{1'b0}};
        cal_data <= {`COGC_DW{1'b0}};
    end else begin
        cal_valid <= s2_vld_r;
        if (s2_vld_r) begin
            cal_chan <= s2_chan_r;
            cal_data <= sat_nxt;
        end
    end
end

endmodule // cogc_cal

/* File: verilog/cogc_map.vh */
`ifndef COGC_MAP_VH
`define COGC_MAP_VH

// Datapath widths
`define COGC_DW 24
`define COGC_CH_N 8
`define COGC_CHW 3
`define COGC_AW 7

// Per-channel byte registers: address = channel * stride + slot
`define COGC_CH_STRIDE 7'h08
`define COGC_CHAN_MSB 5
`define COGC_CHAN_LSB 3
`define COGC_SLOT_MSB 2
`define COGC_SLOT_LSB 0
`define COGC_SLOT_OFS_HI 3'h0
`define COGC_SLOT_OFS_MID 3'h1
`define COGC_SLOT_OFS_LO 3'h2
`define COGC_SLOT_GAIN_HI 3'h3
`define COGC_SLOT_GAIN_MID 3'h4
`define COGC_SLOT_GAIN_LO 3'h5
`define COGC_CH_SPAN 7'h40

// Global control and status bytes
`define COGC_ADDR_CHOP_CTRL 7'h40
`define COGC_ADDR_STATUS 7'h41
`define COGC_CHOP_SEL_BIT 0
`define COGC_STAT_PIN_BIT 0
`define COGC_STAT_CHOP_BIT 1

// Factory coefficients
`define COGC_OFS_FACTORY 24'h000000
`define COGC_GAIN_FACTORY 24'h555555

// Scaling: (raw - offset) * gain / 4 * 4194300 / 2^42
`define COGC_SCALE_MUL 24'h3ffffc
`define COGC_SCALE_SHIFT 44
`define COGC_PROD1_W 50
`define COGC_PROD2_W 74
`define COGC_RES_W 30

// Output saturation limits
`define COGC_OUT_MAX 24'h7fffff
`define COGC_OUT_MIN 24'h800000

// Chop divider terminal counts (ratio minus one)
`define COGC_CHOP_TC_32 5'h1f
`define COGC_CHOP_TC_8 5'h07
`define COGC_CHOP_CW 5

`endif

/* File: verilog/cogc_chop_div.v */
`timescale 1ns/100ps
`include "cogc_map.vh"

module cogc_chop_div (
    input wire ref_clk,
    input wire rst_b,
    input wire mod_tick,
    input wire div8_sel,
    output reg chop_pulse
);

reg [`COGC_CHOP_CW-1:0] cnt_r;
reg [`COGC_CHOP_CW-1:0] cnt_nxt;
wire [`COGC_CHOP_CW-1:0] tc;

// Terminal count follows the selection; a change lands within one chop period
assign tc = div8_sel ? `COGC_CHOP_TC_8 : `COGC_CHOP_TC_32;

// Next count: wraps at the terminal count or if a shorter ratio left it beyond
always @* begin
    cnt_nxt = cnt_r;
    if (mod_tick) begin
        if (cnt_r >= tc) begin
            cnt_nxt = {`COGC_CHOP_CW{1'b0}};
        end else begin
            cnt_nxt = cnt_r + 5'h01;
        end
    end
end

// Count modulator ticks, one chop pulse per wrap
always @(posedge ref_clk) begin
    if (!rst_b) begin
        cnt_r <= {`COGC_CHOP_CW{1'b0}};
        chop_pulse <= 1'b0;
    end else begin
        cnt_r <= cnt_nxt;
        chop_pulse <= mod_tick && (cnt_r >= tc);
    end
end

endmodule // cogc_chop_div

/* File: test/cogc_cal_properties.sv */
`timescale 1ns/100ps
module cogc_cal_props (
    input wire ref_clk,
    input wire rst_b,
    input wire pin_ctrl_mode,
    input wire mod_tick,
    input wire [6:0] reg_addr,
    input wire reg_rd_en,
    input wire [7:0] reg_rdata,
    input wire raw_valid,
    input wire [2:0] raw_chan,
    input wire cal_valid,
    input wire [2:0] cal_chan,
    input wire chop_div8,
    input wire chop_pulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // A chop period is never shorter than the /8 ratio
    sequence s_chop_quiet;
        !chop_pulse [*7];
    endsequence
    // Strap held long enough to pass the two-flop sync
    sequence s_pin_held;
        pin_ctrl_mode [*6];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    cal_latency_a:
        assert property (raw_valid |-> ##3 cal_valid) else $error("result late or missing");
    cal_chan_a:
        assert property (cal_valid |-> $past(raw_valid, 3) && cal_chan == $past(raw_chan, 3)) else $error("bad channel");
    chop_origin_a:
        assert property (chop_pulse |-> $past(mod_tick)) else $error("chop pulse without tick");
    chop_gap_a:
        assert property (chop_pulse |=> s_chop_quiet) else $error("chop pulses too close");
    pin_chop_a:
        assert property (s_pin_held |-> !chop_div8) else $error("fast chop in strap mode");
    unmapped_rd_a:
        assert property (reg_rd_en && !reg_addr[6] && reg_addr[2:1] == 2'h3 |=> reg_rdata == 8'h00) else $error("hole");
    status_rd_a:
        assert property (reg_rd_en && reg_addr == 7'h41 |=> reg_rdata[7:1] == {6'h00, $past(chop_div8)}) else $error("st");
    rdata_hold_a:
        assert property (!reg_rd_en |=> $stable(reg_rdata)) else $error("read data moved");
endmodule // cogc_cal_props
bind cogc_cal cogc_cal_props i_cogc_cal_props (.ref_clk(ref_clk), .rst_b(rst_b), .pin_ctrl_mode(pin_ctrl_mode),
    .mod_tick(mod_tick), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .raw_valid(raw_valid),
    .raw_chan(raw_chan), .cal_valid(cal_valid), .cal_chan(cal_chan), .chop_div8(chop_div8), .chop_pulse(chop_pulse));

/* File: test/cogc_host.sv */
`timescale 1ns/100ps
module cogc_host (
    input wire ref_clk,
    output reg [6:0] reg_addr,
    output reg reg_wr_en,
    output reg [7:0] reg_wdata,
    output reg reg_rd_en,
    input wire [7:0] reg_rdata
);
    // Idle port at time zero
    initial begin
        reg_addr = 7'h7f;
        reg_wr_en = 1'h0;
        reg_wdata = 8'h00;
        reg_rd_en = 1'h0;
    end
    // One byte write; released lines show the inverse so stale values never match
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'h1;
        @(posedge ref_clk);
        reg_wr_en <= 1'h0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // Read one byte; sampled a cycle late since the data holds until the next read
    task rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd_en <= 1'h1;
        @(posedge ref_clk);
        reg_rd_en <= 1'h0;
        reg_addr <= ~a;
        @(posedge ref_clk);
        #1 d = reg_rdata;
    endtask
    // Coefficient goes out high, middle, low byte
    task wr24(input logic [6:0] a, input logic [23:0] v);
        wr(a, v[23:16]);
        wr(a + 7'h01, v[15:8]);
        wr(a + 7'h02, v[7:0]);
    endtask
endmodule // cogc_host

/* File: test/channel_offset_gain_calibration_tb_top.sv */
`timescale 1ns/100ps
module channel_offset_gain_calibration_tb_top;
    typedef struct packed {logic [2:0] ch; logic [23:0] raw; logic [23:0] ofs; logic [23:0] gain; logic [23:0] res;} cogc_row_t;
    logic ref_clk, rst_b, pin_ctrl_mode, mod_tick, reg_wr_en, reg_rd_en, raw_valid, cal_valid, chop_div8, chop_pulse;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rb;
    logic [2:0] raw_chan, cal_chan;
    logic [23:0] raw_data, cal_data;
    int failures = 0;
    int n_checks = 0;
    int gap, i;
    // Nominal, offset step, formula, both clamps, offset before gain; floored result last
    cogc_row_t rows [6] = '{{3'h0, 24'h000003, 24'h000000, 24'h555555, 24'h000003},
        {3'h5, 24'h000000, 24'h000064, 24'h555555, 24'hffff7a}, {3'h7, 24'h100000, 24'h0000ff, 24'h555575, 24'h155407},
        {3'h2, 24'h7fffff, 24'h800000, 24'hffffff, 24'h7fffff}, {3'h6, 24'h800000, 24'h7fffff, 24'hffffff, 24'h800000},
        {3'h1, 24'h000000, 24'h000064, 24'haaaaaa, 24'hfffef5}};
    cogc_cal i_cogc_cal (.ref_clk(ref_clk), .rst_b(rst_b), .pin_ctrl_mode(pin_ctrl_mode), .mod_tick(mod_tick),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .raw_valid(raw_valid), .raw_chan(raw_chan), .raw_data(raw_data), .cal_valid(cal_valid), .cal_chan(cal_chan),
        .cal_data(cal_data), .chop_div8(chop_div8), .chop_pulse(chop_pulse));
    cogc_host i_cogc_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a modulator tick every other cycle
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) mod_tick <= ~mod_tick;
    // Reference result: wide arithmetic so nothing wraps before the clamp
    function automatic logic [23:0] exp_cal(input logic [23:0] r, input logic [23:0] o, input logic [23:0] g);
        logic signed [79:0] p;
        p = ($signed({{56{r[23]}}, r}) - $signed({{56{o[23]}}, o})) * $signed({56'h0, g}) * 80'sh3ffffc;
        p = p >>> 44;
        if (p > 80'sh7fffff) return 24'h7fffff;
        else if (p < -80'sh800000) return 24'h800000;
        return p[23:0];
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Cycles between two chop pulses, bounded so a dead divider cannot hang
    task chop_gap(output int n);
        n = 0;
        while (chop_pulse !== 1'h1 && n < 200) begin
            @(posedge ref_clk);
            #1 n++;
        end
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (chop_pulse !== 1'h1 && n < 200);
    endtask
    task do_reset;
        @(posedge ref_clk);
        rst_b <= 1'h0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge ref_clk);
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        #400000;
        failures++;
        conclude;
    end
    initial begin
        ref_clk = 1'h0;
        rst_b = 1'h0;
        mod_tick = 1'h0;
        pin_ctrl_mode = 1'h0;
        raw_valid = 1'h0;
        raw_chan = 3'h0;
        raw_data = 24'h000000;
        do_reset;
        for (i = 0; i < 64; i++) begin
            i_cogc_host.rd(i[6:0], rb);
            if (i % 8 < 6) chk(rb, (i % 8 < 3) ? 8'h00 : 8'h55);
        end
        i_cogc_host.rd(7'h40, rb);
        chk(rb, 8'h00);
        i_cogc_host.wr(7'h0e, 8'ha5);
        i_cogc_host.rd(7'h0e, rb);
        chk(rb, 8'h00);
        chop_gap(gap);
        chop_gap(gap);
        chk(gap, 64);
        // Table of ordinary cases
        foreach (rows[r]) begin
            i_cogc_host.wr24({rows[r].ch, 4'h0} >> 1, rows[r].ofs);
            i_cogc_host.wr24(({rows[r].ch, 4'h0} >> 1) + 7'h03, rows[r].gain);
            @(posedge ref_clk);
            raw_valid <= 1'h1;
            raw_chan <= rows[r].ch;
            raw_data <= rows[r].raw;
            @(posedge ref_clk);
            raw_valid <= 1'h0;
            raw_chan <= ~rows[r].ch;
            raw_data <= ~rows[r].raw;
            gap = 0;
            do begin
                @(posedge ref_clk);
                #1 gap++;
            end while (cal_valid !== 1'h1 && gap < 8);
            chk(cal_chan, rows[r].ch);
            chk(cal_data, exp_cal(rows[r].raw, rows[r].ofs, rows[r].gain));
            chk(cal_data, rows[r].res);
            chk(gap, 2);
        end
        // Fast chop, then strap mode forces it back and locks writes
        i_cogc_host.wr(7'h40, 8'h01);
        chop_gap(gap);
        chop_gap(gap);
        chk(gap, 16);
        i_cogc_host.rd(7'h41, rb);
        chk(rb, 8'h02);
        pin_ctrl_mode <= 1'h1;
        repeat (8) @(posedge ref_clk);
        #1 chk(chop_div8, 1'h0);
        i_cogc_host.wr(7'h05, 8'h00);
        i_cogc_host.rd(7'h05, rb);
        chk(rb, 8'h55);
        i_cogc_host.rd(7'h41, rb);
        chk(rb[0], 1'h1);
        chop_gap(gap);
        chop_gap(gap);
        chk(gap, 64);
        pin_ctrl_mode <= 1'h0;
        // Reset discards host values
        do_reset;
        i_cogc_host.rd(7'h3d, rb);
        chk(rb, 8'h55);
        i_cogc_host.rd(7'h3a, rb);
        chk(rb, 8'h00);
        i_cogc_host.rd(7'h40, rb);
        chk(rb, 8'h00);
        conclude;
    end
endmodule // channel_offset_gain_calibration_tb_top
